/* File: rts_pkg.sv */
// Package of constants, types and register map for the relay test supervisor.
`default_nettype none

package rts_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLOCK_HZ          = 100_000_000;
    localparam int unsigned SECONDS_REMIND    = 11 * 3600;
    localparam int unsigned SECONDS_SELF      = 11 * 3600 + 50 * 60;
    localparam int unsigned SECONDS_FORCE     = 12 * 3600;
    localparam int unsigned BEEP_PERIOD_S     = 2;
    localparam int unsigned TICKS_PER_SEC     = CLOCK_HZ;
    localparam int unsigned BEEP_LEN_MS       = 100;
    localparam int unsigned BEEP_LEN_CYC      = CLOCK_HZ / 1000 * BEEP_LEN_MS;
    localparam int unsigned OPEN_TIME_MS      = 50;
    localparam int unsigned OPEN_CYC          = CLOCK_HZ / 1000 * OPEN_TIME_MS;
    localparam int unsigned SQW_HALF_CYC      = 50_000;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_ELAPSED = 8'h08;
    localparam logic [7:0] ADDR_INPUTS  = 8'h0c;

    // Control bit positions.
    localparam int unsigned CTL_REQ     = 0;
    localparam int unsigned CTL_GEARVAR = 1;
    localparam int unsigned CTL_TEACH   = 2;
    localparam int unsigned CTL_CLRERR  = 3;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_OPEN  = 4'b0010,
        ST_CHECK = 4'b0100,
        ST_FAULT = 4'b1000
    } rts_state_e;

    typedef struct packed {
        logic bridge;
        logic hard;
        logic gear;
    } rts_relay_s;

endpackage

`default_nettype wire

/* File: relay_test_supervisor.sv */
// Relay test supervisor with field input handling and AHB-Lite registers.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none

module relay_test_supervisor
    import rts_pkg::*;
#(
    parameter int unsigned SEC_CYC  = TICKS_PER_SEC, // Cycles per second.
    parameter int unsigned OPEN_LEN = OPEN_CYC,      // Relay open window.
    parameter int unsigned BEEP_LEN = BEEP_LEN_CYC,  // Beep length.
    parameter int unsigned SQW_HALF = SQW_HALF_CYC   // Square half period.
) (
    input  wire logic             clock,             // System clock.
    input  wire logic             reset,             // Synchronous reset.
    input  wire logic             hsel,              // AHB select.
    input  wire logic [31:0]      haddr,             // AHB address.
    input  wire logic [1:0]       htrans,            // AHB transfer type.
    input  wire logic             hwrite,            // AHB write.
    input  wire logic [2:0]       hsize,             // AHB size.
    input  wire logic             hready,            // AHB ready in.
    input  wire logic [31:0]      hwdata,            // AHB write data.
    output logic [31:0]           hrdata,            // AHB read data.
    output logic                  hreadyout,         // AHB ready out.
    output logic                  hresp,             // AHB response.
    input  wire logic             carStill,          // Car at standstill.
    input  wire rts_pkg::rts_relay_s relayFeedback,  // Relay feedback pins.
    input  wire logic             gearTripFeedback,  // Gear feedback pin.
    input  wire logic             doorCircuitSense,  // Door circuit end pin.
    input  wire logic             inspectionSwitchIn, // Inspection switch pin.
    input  wire logic             upButtonIn,        // Up button pin.
    input  wire logic             downButtonIn,      // Down button pin.
    input  wire logic             zonePresent,       // Door zone from position.
    input  wire logic             resetButtonIn,     // External reset pin.
    output rts_pkg::rts_relay_s   relayClose,        // Contact close drives.
    output logic                  buttonSquareSupply, // Square wave supply.
    output logic                  zoneIndicatorOut,  // Zone indicator contact.
    output logic                  reminderPulse,     // Reminder message strobe.
    output logic                  systemError,       // System error flag.
    output logic                  buzzer             // Buzzer drive.
);
    import rts_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [8:0] syncA_reg;
    logic [8:0] syncB_reg;
    logic [8:0] pinIn;
    assign pinIn = {relayFeedback, gearTripFeedback, doorCircuitSense,
                    inspectionSwitchIn, upButtonIn, downButtonIn, resetButtonIn};

    // Two flops so that no logic reads a metastable sample of these nine pins; carStill and zonePresent do not pass through them.
    always_ff @(posedge clock) begin
        if (reset) begin
            syncA_reg <= 9'h000;
            syncB_reg <= 9'h000;
        end else begin
            syncA_reg <= pinIn;
            syncB_reg <= syncA_reg;
        end
    end

    logic [2:0] fbSync;
    logic       gearFbSync;
    logic       doorsClosed;
    logic       rawInsp;
    logic       rawUp;
    logic       rawDown;
    logic       buttonReset;
    assign fbSync      = syncB_reg[8:6];
    assign gearFbSync  = syncB_reg[5];
    assign doorsClosed = syncB_reg[4];
    assign rawInsp     = syncB_reg[3];
    assign rawUp       = syncB_reg[2];
    assign rawDown     = syncB_reg[1];
    assign buttonReset = syncB_reg[0];

    // ****************************************************************
    // Square supply and button decode
    // ****************************************************************
    logic [31:0] sqwCount_reg;
    logic        sqw_reg;
    logic        inspMode_reg;
    logic        upPressed_reg;
    logic        downPressed_reg;

    // square supply
    // Inputs are compared with the square phase each half period, so a stuck-high wire reads pressed every other half period.
    always_ff @(posedge clock) begin
        if (reset) begin
            sqwCount_reg    <= 32'h0;
            sqw_reg         <= 1'b0;
            inspMode_reg    <= 1'b0;
            upPressed_reg   <= 1'b0;
            downPressed_reg <= 1'b0;
        end else if (sqwCount_reg == SQW_HALF - 1) begin
            sqwCount_reg    <= 32'h0;
            sqw_reg         <= ~sqw_reg;
            inspMode_reg    <= (rawInsp == sqw_reg);
            upPressed_reg   <= (rawUp == sqw_reg);
            downPressed_reg <= (rawDown == sqw_reg);
        end else begin
            sqwCount_reg <= sqwCount_reg + 32'h1;
        end
    end
    assign buttonSquareSupply = sqw_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            zoneIndicatorOut <= 1'b0;
        end else begin
            zoneIndicatorOut <= zonePresent;
        end
    end

    // ****************************************************************
    // Seconds tick and elapsed time
    // ****************************************************************
    logic [31:0] tickCount_reg;
    logic        secTick;
    logic [31:0] elapsed_reg;
    logic        testPass;
    logic        testReq_reg;
    logic        control_gear;
    logic        control_teach;

    assign secTick = (tickCount_reg == SEC_CYC - 1);

    always_ff @(posedge clock) begin
        if (reset || secTick) begin
            tickCount_reg <= 32'h0;
        end else begin
            tickCount_reg <= tickCount_reg + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || testPass) begin
            elapsed_reg <= 32'h0;
        end else if (secTick && elapsed_reg < SECONDS_FORCE) begin
            elapsed_reg <= elapsed_reg + 32'h1;
        end
    end

    logic remindDue;
    logic selfDue;
    logic forceDue;
    assign remindDue = elapsed_reg >= SECONDS_REMIND;
    assign selfDue   = elapsed_reg >= SECONDS_SELF;
    assign forceDue  = elapsed_reg >= SECONDS_FORCE;

    always_ff @(posedge clock) begin
        if (reset) begin
            reminderPulse <= 1'b0;
        end else begin
            reminderPulse <= remindDue && secTick && !testPass;
        end
    end

    // ****************************************************************
    // Test sequencer
    // ****************************************************************
    rts_state_e  state_reg;
    logic [31:0] phaseCount_reg;
    logic [2:0]  fbClosed_reg;
    logic        gearClosed_reg;
    logic [2:0]  fbSeen_reg;
    logic        gearSeen_reg;
    logic        startTest;
    logic        phaseDone;

    assign startTest = testReq_reg || (selfDue && carStill) || forceDue;
    assign phaseDone = (phaseCount_reg == OPEN_LEN - 1);

    always_ff @(posedge clock) begin
        if (reset || state_reg == ST_IDLE || phaseDone) begin
            phaseCount_reg <= 32'h0;
        end else begin
            phaseCount_reg <= phaseCount_reg + 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg      <= ST_IDLE;
            fbClosed_reg   <= 3'b000;
            gearClosed_reg <= 1'b0;
            fbSeen_reg     <= 3'b000;
            gearSeen_reg   <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (startTest) begin
                        fbClosed_reg   <= fbSync;
                        gearClosed_reg <= gearFbSync;
                        fbSeen_reg     <= 3'b000;
                        gearSeen_reg   <= 1'b0;
                        state_reg      <= ST_OPEN;
                    end
                end
                ST_OPEN: begin
                    fbSeen_reg   <= fbSeen_reg | (fbSync ^ fbClosed_reg);
                    gearSeen_reg <= gearSeen_reg | (gearFbSync ^ gearClosed_reg);
                    if (phaseDone) begin
                        state_reg <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    // gear feedback only in gear variant
                    if (fbSeen_reg != 3'b111 || (control_gear && !gearSeen_reg)) begin
                        state_reg <= ST_FAULT;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_FAULT: begin
                    if (buttonReset) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign testPass = (state_reg == ST_CHECK) && (fbSeen_reg == 3'b111)
                      && !(control_gear && !gearSeen_reg);

    always_ff @(posedge clock) begin
        if (reset) begin
            relayClose  <= '{bridge: 1'b0, hard: 1'b0, gear: 1'b0};
            systemError <= 1'b0;
        end else begin
            relayClose.bridge <= (state_reg == ST_IDLE);
            relayClose.gear   <= (state_reg == ST_IDLE);
            relayClose.hard   <= (state_reg == ST_IDLE) && doorsClosed;
            systemError       <= (state_reg == ST_FAULT);
        end
    end

    // ****************************************************************
    // Buzzer
    // ****************************************************************
    logic [31:0] beepSec_reg;
    logic [31:0] beepCount_reg;

    always_ff @(posedge clock) begin
        if (reset || !control_teach) begin
            beepSec_reg   <= 32'h0;
            beepCount_reg <= 32'h0;
            buzzer        <= 1'b0;
        end else begin
            if (secTick) begin
                beepSec_reg <= (beepSec_reg == BEEP_PERIOD_S - 1) ? 32'h0 : beepSec_reg + 32'h1;
            end
            if (secTick && beepSec_reg == 32'h0) begin
                beepCount_reg <= 32'h0;
                buzzer        <= 1'b1;
            end else if (buzzer) begin
                beepCount_reg <= beepCount_reg + 32'h1;
                buzzer        <= (beepCount_reg < BEEP_LEN - 1);
            end
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    logic       wrPend_reg;
    logic [7:0] addr_reg;
    logic       accept;
    logic [1:0] ctlBits_reg;
    assign accept = hsel && hready && htrans[1];
    assign control_gear  = ctlBits_reg[0];
    assign control_teach = ctlBits_reg[1];

    always_ff @(posedge clock) begin
        if (reset) begin
            wrPend_reg <= 1'b0;
            addr_reg   <= 8'h00;
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0;
        end else begin
            wrPend_reg <= accept && hwrite;
            if (accept) begin
                addr_reg <= haddr[7:0];
                case (haddr[7:0])
                    ADDR_STATUS:  hrdata <= {24'h0, state_reg, 1'b0, forceDue,
                                             selfDue, remindDue};
                    ADDR_ELAPSED: hrdata <= elapsed_reg;
                    ADDR_INPUTS:  hrdata <= {26'h0, zoneIndicatorOut, buttonReset,
                                             downPressed_reg, upPressed_reg,
                                             inspMode_reg, !doorsClosed};
                    ADDR_CONTROL: hrdata <= {29'h0, control_teach, control_gear, testReq_reg};
                    default:      hrdata <= 32'h0;
                endcase
            end
        end
    end

    // Request is cleared by the test start; a new write in that cycle wins.
    always_ff @(posedge clock) begin
        if (reset) begin
            ctlBits_reg <= CONTROL_RESET[1:0];
            testReq_reg <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE && startTest) begin
                testReq_reg <= 1'b0;
            end
            if (wrPend_reg && addr_reg == ADDR_CONTROL) begin
                ctlBits_reg <= {hwdata[CTL_TEACH], hwdata[CTL_GEARVAR]};
                if (hwdata[CTL_REQ]) begin
                    testReq_reg <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_fault_opens: assert property (
        state_reg == ST_FAULT |=> !relayClose.bridge && !relayClose.hard && !relayClose.gear)
        else $error("Contacts closed during fault.");
    a_idle_closed: assert property (
        state_reg == ST_IDLE |=> relayClose.bridge && relayClose.gear)
        else $error("Contacts open while idle.");
    a_force_starts: assert property (
        state_reg == ST_IDLE && forceDue |=> state_reg == ST_OPEN)
        else $error("Forced test did not start.");
    a_self_still: assert property (
        state_reg == ST_IDLE && selfDue && carStill |=> state_reg == ST_OPEN)
        else $error("Standstill test did not start.");
    a_remind_due: assert property (
        reminderPulse |-> $past(remindDue))
        else $error("Reminder sent too early.");
    a_pass_clears: assert property (
        testPass |=> elapsed_reg == 32'h0)
        else $error("Timer not cleared after pass.");
    a_check_fault: assert property (
        state_reg == ST_CHECK && fbSeen_reg != 3'b111 |=> state_reg == ST_FAULT)
        else $error("Missing feedback not flagged.");
    a_error_out: assert property (
        state_reg == ST_FAULT |=> systemError)
        else $error("Error flag not raised.");
    a_zone_follow: assert property (
        zoneIndicatorOut == $past(zonePresent))
        else $error("Zone indicator lags.");

    c_test_pass:  cover property (testPass);
    c_test_fault: cover property (state_reg == ST_CHECK ##1 state_reg == ST_FAULT);
    c_reminder:   cover property (reminderPulse);

endmodule

`default_nettype wire

/* File: rts_field_model.sv */
// Field-side model of the safety relays, their feedback contacts and the inspection buttons.
`default_nettype none

module rts_field_model
    import rts_pkg::*;
(
    input  wire logic                clock,    // System clock.
    input  wire rts_pkg::rts_relay_s relayClose, // Contact drives from the supervisor.
    input  wire logic                squareIn, // Square wave supply of the buttons.
    input  wire logic [3:0]          stuck,    // Frozen feedback: 3 gear switch, 2:0 relays.
    input  wire logic [2:0]          press,    // Closed: 0 inspection, 1 up, 2 down.
    output rts_pkg::rts_relay_s      feedback, // Relay feedback lines.
    output logic                     gearFb,   // Gear switch feedback line.
    output logic [2:0]               buttons   // Returned button lines.
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Relay contacts
    // ****************************************************************
    // Feedback lags the drive by one cycle, as a real armature does; a stuck contact
    // keeps its last level, which is exactly the fault the periodic test must catch.
    initial begin
        feedback = 3'b000;
        gearFb   = 1'b0;
    end
    always @(posedge clock) begin
        if (!stuck[2]) feedback.bridge <= relayClose.bridge;
        if (!stuck[1]) feedback.hard <= relayClose.hard;
        if (!stuck[0]) feedback.gear <= relayClose.gear;
        if (!stuck[3]) gearFb <= relayClose.gear;
    end

    // ****************************************************************
    // Inspection buttons
    // ****************************************************************
    // closed switch returns supply
    // An open switch returns the inverse; a constant level reads as pressed on every other half period.
    assign buttons = press ^ ~{3{squareIn}};
endmodule

`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the relay test supervisor.
`default_nettype none
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin miscompares++; \
    $display("ERROR %0t: value %h expected %h", $time, (act), (exp)); end end

module tb
    import rts_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int unsigned OPEN_N = 8;
    logic        clock, reset, hsel, hwrite, hreadyout, hresp, carStill;
    logic        doorCircuitSense, zonePresent, resetButtonIn, gearTripFeedback;
    logic        buttonSquareSupply, zoneIndicatorOut, reminderPulse, systemError, buzzer;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [3:0]  stuck;
    logic [2:0]  press, buttons;
    rts_relay_s  relayFeedback, relayClose;
    int          checks, miscompares;

    relay_test_supervisor #(.SEC_CYC(1), .OPEN_LEN(OPEN_N), .BEEP_LEN(3), .SQW_HALF(4)) i_dut (
        .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .carStill(carStill),
        .relayFeedback(relayFeedback), .gearTripFeedback(gearTripFeedback),
        .doorCircuitSense(doorCircuitSense), .inspectionSwitchIn(buttons[0]),
        .upButtonIn(buttons[1]), .downButtonIn(buttons[2]), .zonePresent(zonePresent),
        .resetButtonIn(resetButtonIn), .relayClose(relayClose),
        .buttonSquareSupply(buttonSquareSupply), .zoneIndicatorOut(zoneIndicatorOut),
        .reminderPulse(reminderPulse), .systemError(systemError), .buzzer(buzzer));

    rts_field_model i_field (.clock(clock), .relayClose(relayClose),
        .squareIn(buttonSquareSupply), .stuck(stuck), .press(press),
        .feedback(relayFeedback), .gearFb(gearTripFeedback), .buttons(buttons));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // One single AHB-Lite transfer; only the watchdog ends a wait on a dead slave.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    // Read a register and compare the masked bits.
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        `CHK(d & m, e)
    endtask

    // Wait a bounded time for the bridgeable contact to reach a level.
    task automatic waitBridge(input logic v);
        int n;
        n = 0;
        while (relayClose.bridge !== v && n < 200) begin @(posedge clock); n++; end
        `CHK(relayClose.bridge, v)
    endtask

    // Count edges until the square supply shows a level.
    task automatic waitSq(input logic v, output int n);
        n = 0;
        while (buttonSquareSupply !== v && n < 20) begin @(posedge clock); n++; end
    endtask

    // Requested relay test with the given feedback faults, ending in state st.
    task automatic runTest(input logic [31:0] ctl, input logic [3:0] s, input logic [3:0] st);
        logic [31:0] d;
        stuck <= s;
        bus(1'b1, ADDR_CONTROL, ctl, d);
        waitBridge(1'b0);
        `CHK(relayClose, 3'b000)
        repeat (OPEN_N + 10) @(posedge clock);
        rchk(ADDR_STATUS, 32'hf0, {24'h0, st, 4'h0});
        `CHK(systemError, st[3])
        `CHK(relayClose, (st[3] ? 3'b000 : 3'b111))
    endtask

    // The external button is the only way out of the fault state.
    task automatic clearFault();
        resetButtonIn <= 1'b1;
        repeat (6) @(posedge clock);
        resetButtonIn <= 1'b0;
        repeat (6) @(posedge clock);
        rchk(ADDR_STATUS, 32'hf0, 32'h10);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and tests
    // ****************************************************************
    // Free-running system clock.
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // The long-interval runs take about 87k cycles; allow some margin.
    initial begin
        #950_000;
        miscompares++;
        $display("ERROR %0t: timeout", $time);
        end_of_test();
    end

    // Main sequence.
    initial begin
        logic [31:0] d;
        int          n, first, pulses;
        checks = 0; miscompares = 0;
        reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hwdata = 32'h0; carStill = 1'b1; doorCircuitSense = 1'b1; zonePresent = 1'b0;
        resetButtonIn = 1'b0; stuck = 4'h0; press = 3'b000;
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        // The door input needs its two synchroniser stages before the hard contact closes.
        repeat (4) @(posedge clock);
        `CHK(relayClose, 3'b111)
        rchk(ADDR_STATUS, 32'hf7, 32'h10);
        rchk(8'h10, 32'hffff_ffff, 32'h0);
        doorCircuitSense <= 1'b0;
        repeat (6) @(posedge clock);
        rchk(ADDR_INPUTS, 32'h1, 32'h1);
        `CHK(relayClose, 3'b101)
        doorCircuitSense <= 1'b1;
        repeat (6) @(posedge clock);
        rchk(ADDR_INPUTS, 32'h1, 32'h0);
        for (int k = 0; k < 4; k++) begin
            press <= (k == 3) ? 3'b000 : 3'(1 << k);
            repeat (20) @(posedge clock);
            rchk(ADDR_INPUTS, 32'he, {28'h0, press, 1'b0});
        end
        waitSq(1'b0, n);
        waitSq(1'b1, n);
        waitSq(1'b0, n);
        `CHK(n, 4)
        zonePresent <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK(zoneIndicatorOut, 1'b1)
        rchk(ADDR_INPUTS, 32'h20, 32'h20);
        resetButtonIn <= 1'b1;
        repeat (5) @(posedge clock);
        rchk(ADDR_INPUTS, 32'h10, 32'h10);
        resetButtonIn <= 1'b0;
        bus(1'b1, ADDR_CONTROL, 32'h4, d);
        n = 0;
        while (buzzer !== 1'b1 && n < 20) begin @(posedge clock); n++; end
        `CHK(buzzer, 1'b1)
        bus(1'b1, ADDR_CONTROL, 32'h0, d);
        repeat (10) @(posedge clock);
        `CHK(buzzer, 1'b0)
        runTest(32'h1, 4'h0, 4'h1);
        runTest(32'h1, 4'h8, 4'h1);
        for (int i = 0; i < 3; i++) begin
            runTest(32'h1, 4'(1 << i), 4'h8);
            clearFault();
        end
        runTest(32'h3, 4'h8, 4'h8);
        clearFault();
        runTest(32'h3, 4'h0, 4'h1);
        carStill <= 1'b0;
        bus(1'b1, ADDR_CONTROL, 32'h1, d);
        waitBridge(1'b0);
        waitBridge(1'b1);
        n = 0; first = 0; pulses = 0;
        while (n < 42610) begin
            @(posedge clock);
            n++;
            if (reminderPulse === 1'b1) begin
                if (pulses == 0) first = n;
                pulses++;
            end
        end
        `CHK((first > 39590 && first < 39610), 1'b1)
        `CHK((pulses > 1), 1'b1)
        `CHK(relayClose.bridge, 1'b1)
        rchk(ADDR_STATUS, 32'h7, 32'h3);
        carStill <= 1'b1;
        waitBridge(1'b0);
        waitBridge(1'b1);
        rchk(ADDR_STATUS, 32'h7, 32'h0);
        carStill <= 1'b0;
        n = 0;
        while (relayClose.bridge === 1'b1 && n < 44000) begin @(posedge clock); n++; end
        `CHK((n > 43180 && n < 43205), 1'b1)
        waitBridge(1'b1);
        end_of_test();
    end
endmodule

`default_nettype wire
